// ==== rtl/prs_pkg.sv ====
package prs_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned PWR_REQ_MS = 20;
  localparam int unsigned PWR_REQ_CYC = (CLK_HZ / 1000) * PWR_REQ_MS + 1;
  localparam int unsigned RST_MIN_US = 120;
  // filter window kept well below the guaranteed minimum pulse
  localparam int unsigned RST_FILT_US = 2;
  localparam int unsigned RST_FILT_CYC = (CLK_HZ / 1000000) * RST_FILT_US;
  localparam int unsigned RST_STRETCH_CYC = 64;
  localparam int unsigned PROT_MS = 1800;
  localparam longint unsigned PROT_CYC =
    longint'(CLK_HZ / 1000) * longint'(PROT_MS);
  localparam int unsigned CNT_W = 32;
  typedef enum logic [1:0] {PRS_OFF, PRS_ON, PRS_HELD, PRS_DOWN} prs_state_e;
endpackage

// ==== rtl/prs_counter.sv ====
`timescale 1ns/1ps
`default_nettype none
module prs_counter
  import prs_pkg::*;
#(
  parameter int W = CNT_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [W-1:0] limit,
  output logic done
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  wire at_lim = (cnt_r >= limit);
  assign cnt_nxt = !run ? '0 : (at_lim ? cnt_r : cnt_r + 1'b1);
  assign done = run && at_lim;
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/prs_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
module prs_sequencer
  import prs_pkg::*;
#(
  parameter int unsigned PWR_REQ_CYCLES = PWR_REQ_CYC,
  parameter longint unsigned PROT_CYCLES = PROT_CYC,
  parameter int unsigned FILT_CYCLES = RST_FILT_CYC,
  parameter int unsigned STRETCH_CYCLES = RST_STRETCH_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic power_on_request,
  input wire logic reset_in_n,
  input wire logic charger_supply_present,
  input wire logic sw_detach,
  input wire logic sw_reg_enable,
  input wire logic sw_power_down,
  output logic reg_enable,
  output logic chip_reset,
  output logic supply_pulldown_en,
  output logic powered_state
);
  logic [2:0] req_s_r;
  logic [2:0] rst_s_r;
  logic [2:0] chg_s_r;
  logic req_r;
  logic rstl_r;
  logic chg_r;
  prs_state_e st_r;
  prs_state_e st_nxt;
  logic filt_r;
  logic [7:0] strch_r;
  logic [7:0] strch_nxt;
  logic [CNT_W-1:0] filt_cnt_r;
  logic creset_r;
  logic regen_r;
  logic pd_r;

  // three-stage sync, change taken once stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      req_s_r <= 3'h0;
      rst_s_r <= 3'h7;
      chg_s_r <= 3'h0;
    end else begin
      req_s_r <= {req_s_r[1:0], power_on_request};
      rst_s_r <= {rst_s_r[1:0], reset_in_n};
      chg_s_r <= {chg_s_r[1:0], charger_supply_present};
    end
  end
  wire req_agree = (req_s_r[1] == req_s_r[2]);
  wire rst_agree = (rst_s_r[1] == rst_s_r[2]);
  wire chg_agree = (chg_s_r[1] == chg_s_r[2]);
  always_ff @(posedge clk) begin
    if (rst) begin
      req_r <= 1'b0;
      rstl_r <= 1'b0;
      chg_r <= 1'b0;
    end else begin
      if (req_agree) req_r <= req_s_r[2];
      if (rst_agree) rstl_r <= !rst_s_r[2];
      if (chg_agree) chg_r <= chg_s_r[2];
    end
  end

  // glitch filter: low must persist FILT_CYCLES before acceptance
  wire filt_lim = (filt_cnt_r >= CNT_W'(FILT_CYCLES));
  always_ff @(posedge clk) begin
    if (rst) begin
      filt_cnt_r <= '0;
      filt_r <= 1'b0;
    end else begin
      filt_cnt_r <= !rstl_r ? '0 : (filt_lim ? filt_cnt_r : filt_cnt_r + 1'b1);
      filt_r <= rstl_r && filt_lim;
    end
  end

  // stretch: reset held STRETCH_CYCLES beyond the filtered pulse
  // count held in 8 bits, so STRETCH_CYCLES must stay below 256
  assign strch_nxt = filt_r ? 8'(STRETCH_CYCLES) :
                     (strch_r != 8'h00 ? strch_r - 8'h01 : 8'h00);
  always_ff @(posedge clk) begin
    if (rst) begin
      strch_r <= 8'h00;
      creset_r <= 1'b1;
    end else begin
      strch_r <= strch_nxt;
      creset_r <= filt_r || (strch_r != 8'h00) || st_r != PRS_ON;
    end
  end

  logic req_done, prot_done;
  // request counts only from off or down, timeout only while a held reset stands
  wire req_run = req_r && (st_r == PRS_OFF || st_r == PRS_DOWN);
  wire prot_run = (st_r == PRS_HELD) && filt_r;
  prs_counter #(.W(CNT_W)) u_req_cnt (
    .clk(clk),
    .rst(rst),
    .run(req_run),
    .limit(CNT_W'(PWR_REQ_CYCLES)),
    .done(req_done)
  );
  prs_counter #(.W(CNT_W)) u_prot_cnt (
    .clk(clk),
    .rst(rst),
    .run(prot_run),
    .limit(CNT_W'(PROT_CYCLES)),
    .done(prot_done)
  );

  wire may_down = !chg_r && !req_r;
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      PRS_OFF: begin
        // software that detached before switching off keeps the button out
        if ((req_done && !sw_detach) || chg_r) st_nxt = PRS_ON;
      end
      PRS_DOWN: begin
        if (req_done || chg_r) st_nxt = PRS_ON;
      end
      PRS_ON: begin
        if (filt_r) st_nxt = PRS_HELD;
        else if (sw_power_down && !chg_r) st_nxt = PRS_OFF;
        else if (sw_detach && !sw_reg_enable && !chg_r) st_nxt = PRS_OFF;
      end
      PRS_HELD: begin
        if (prot_done && may_down) st_nxt = PRS_DOWN;
        else if (!filt_r) st_nxt = PRS_ON;
      end
      default: st_nxt = PRS_OFF;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= PRS_OFF;
    end else begin
      st_r <= st_nxt;
    end
  end

  // detach: software can switch regulators off unless charging, request level ignored in off
  wire run_st = (st_nxt == PRS_ON || st_nxt == PRS_HELD);
  always_ff @(posedge clk) begin
    if (rst) begin
      regen_r <= 1'b0;
      pd_r <= 1'b0;
    end else begin
      regen_r <= run_st;
      pd_r <= filt_r;
    end
  end

  assign reg_enable = regen_r;
  assign chip_reset = creset_r;
  assign supply_pulldown_en = pd_r;
  assign powered_state = (st_r != PRS_OFF && st_r != PRS_DOWN);

  power_up_a: assert property (@(posedge clk) disable iff (rst)
    (st_r == PRS_OFF && ((req_done && !sw_detach) || chg_r))
    |=> st_r == PRS_ON)
    else $error("power up missed");
  chg_keep_a: assert property (@(posedge clk) disable iff (rst)
    (st_r == PRS_HELD && chg_r) |=> st_r != PRS_DOWN)
    else $error("charger present but powered down");
  down_cond_a: assert property (@(posedge clk) disable iff (rst)
    (st_r == PRS_HELD && st_nxt == PRS_DOWN) |-> (prot_done && may_down))
    else $error("power down without timeout");
  pulldown_a: assert property (@(posedge clk) disable iff (rst)
    filt_r |=> supply_pulldown_en)
    else $error("pull-down not enabled");
  stretch_a: assert property (@(posedge clk) disable iff (rst)
    $fell(filt_r) |=> chip_reset [*8])
    else $error("reset not stretched");
  held_stay_a: assert property (@(posedge clk) disable iff (rst)
    (st_r == PRS_ON && filt_r) |=> (st_r == PRS_HELD && reg_enable))
    else $error("rails dropped on reset");
  detach_a: assert property (@(posedge clk) disable iff (rst)
    (st_r == PRS_ON && sw_detach && sw_reg_enable && !filt_r
     && !sw_power_down) |=> st_r == PRS_ON)
    else $error("detached regulator left software control");
  sync_rel_a: assert property (@(posedge clk) disable iff (rst)
    $fell(chip_reset) |-> $past(st_r) == PRS_ON)
    else $error("reset released outside on state");
  detach_off_a: assert property (@(posedge clk) disable iff (rst)
    (st_r == PRS_OFF && sw_detach && !chg_r) |=> !reg_enable)
    else $error("detached regulators woke on request");
  filt_wait_a: assert property (@(posedge clk) disable iff (rst)
    filt_r |-> $past(rstl_r, FILT_CYCLES))
    else $error("reset accepted before filter window");
  rails_held_a: assert property (@(posedge clk) disable iff (rst)
    st_r == PRS_HELD |-> reg_enable)
    else $error("rails off while reset held");
  pulldown_off_a: assert property (@(posedge clk) disable iff (rst)
    !filt_r |=> !supply_pulldown_en)
    else $error("pull-down left on after reset");
  off_reset_a: assert property (@(posedge clk) disable iff (rst)
    (st_r != PRS_ON) |=> chip_reset)
    else $error("chip left reset outside on state");
  down_stay_a: assert property (@(posedge clk) disable iff (rst)
    (st_r == PRS_DOWN && !req_done && !chg_r) |=> st_r == PRS_DOWN)
    else $error("restart without request or charger");
  reg_off_a: assert property (@(posedge clk) disable iff (rst)
    st_r == PRS_DOWN |-> !reg_enable)
    else $error("regulators on after timeout");
  chg_wake_a: assert property (@(posedge clk) disable iff (rst)
    (st_r == PRS_DOWN && chg_r) |=> st_r == PRS_ON)
    else $error("charger attach did not restart");
endmodule
`default_nettype wire

// ==== bench/prs_board.sv ====
`timescale 1ns/1ps
`default_nettype none
module prs_board (
  input wire logic clk,
  output logic power_on_request,
  output logic reset_in_n,
  output logic charger_supply_present
);
  // released reset pin sits high: it has a strong pull-up
  initial begin
    power_on_request = 1'b0;
    reset_in_n = 1'b1;
    charger_supply_present = 1'b0;
  end
  task automatic press(input int n);
    @(posedge clk) power_on_request <= 1'b1;
    repeat (n) @(posedge clk);
    power_on_request <= 1'b0;
  endtask
  task automatic hold_reset(input int n);
    @(posedge clk) reset_in_n <= 1'b0;
    repeat (n) @(posedge clk);
    reset_in_n <= 1'b1;
  endtask
  task automatic charger(input logic v);
    @(posedge clk) charger_supply_present <= v;
  endtask
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic det = 1'b0;
  logic sw_en = 1'b0;
  logic sw_pd = 1'b0;
  wire logic req, rin_n, chg, reg_en, crst, pd, pwr;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [31:0] seed = 32'hdb500cdb;
  always #10 clk = ~clk;
  prs_board prs_board_inst (.clk(clk), .power_on_request(req),
    .reset_in_n(rin_n), .charger_supply_present(chg));
  prs_sequencer #(.PWR_REQ_CYCLES(20), .PROT_CYCLES(200),
    .FILT_CYCLES(4), .STRETCH_CYCLES(8)) prs_sequencer_inst (
    .clk(clk), .rst(rst), .power_on_request(req), .reset_in_n(rin_n),
    .charger_supply_present(chg), .sw_detach(det), .sw_reg_enable(sw_en),
    .sw_power_down(sw_pd), .reg_enable(reg_en), .chip_reset(crst),
    .supply_pulldown_en(pd), .powered_state(pwr));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic conclude();
    if (miscompares == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // sample 1 ns after the edge so registered outputs have landed
  task automatic chk(input logic got, input logic exp);
    #1;
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic sw_off();
    @(posedge clk) sw_pd <= 1'b1;
    @(posedge clk) sw_pd <= 1'b0;
    idle(8);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    idle(12);
    rst <= 1'b0;
    idle(3);
    chk(reg_en, 1'b0);
    chk(crst, 1'b1);
    seed = lfsr(seed);
    prs_board_inst.press(1 + seed[3:0]);
    idle(10);
    chk(reg_en, 1'b0);
    prs_board_inst.press(40);
    idle(10);
    chk(reg_en, 1'b1);
    chk(pwr, 1'b1);
    chk(crst, 1'b0);
    // glitches kept below the filter window
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      prs_board_inst.hold_reset(1 + seed[1:0] % 3);
      idle(8);
      chk(crst, 1'b0);
    end
    prs_board_inst.hold_reset(30);
    chk(pd, 1'b1);
    chk(crst, 1'b1);
    chk(reg_en, 1'b1);
    idle(30);
    chk(crst, 1'b0);
    chk(pd, 1'b0);
    prs_board_inst.hold_reset(300);
    chk(reg_en, 1'b0);
    chk(pwr, 1'b0);
    idle(30);
    chk(reg_en, 1'b0);
    prs_board_inst.charger(1'b1);
    idle(20);
    chk(reg_en, 1'b1);
    // random software controls cannot drop the rails while charging
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      @(posedge clk);
      det <= seed[0];
      sw_en <= seed[1];
      sw_pd <= seed[2];
      chk(reg_en, 1'b1);
    end
    @(posedge clk);
    det <= 1'b0;
    sw_en <= 1'b0;
    sw_pd <= 1'b0;
    chk(reg_en, 1'b1);
    prs_board_inst.hold_reset(300);
    chk(reg_en, 1'b1);
    idle(30);
    sw_off();
    chk(reg_en, 1'b1);
    prs_board_inst.charger(1'b0);
    // let the synchroniser see the charger gone before asking to power off
    idle(6);
    sw_off();
    chk(reg_en, 1'b0);
    prs_board_inst.press(40);
    idle(10);
    det <= 1'b1;
    sw_en <= 1'b1;
    idle(10);
    chk(reg_en, 1'b1);
    sw_en <= 1'b0;
    idle(10);
    chk(reg_en, 1'b0);
    prs_board_inst.press(40);
    idle(10);
    chk(reg_en, 1'b0);
    conclude();
  end
endmodule
`default_nettype wire
